//--- rtl/mbs_module_bus.sv
// Function
// - direction line picks drive or read
// - data-or-address line marks address loads
// - pointer line picks program or data pointer
// - stack line pushes or pops return stack
// - active only when module number matches
// - bus outputs combine as wired-or
// - module is 256 words or one port
// - data bus carries intramodule word address
// - port access carries data word only
// - eleventh address bit picks pair chip
// - address loads select group of eight
// - module bit three picks reading chip
// - buffer pairs decode range 48 to 63
// - port reads pins wire-ored with latches
// - port latches clear at reset
// - processor port has four latches only
// - module samples processor data in T7-T8
// - module discharges bus in T7-T8
// - bus data is inverted
`timescale 1ns/1ns
`default_nettype none
`include "mbs_defines.svh"
module mbs_module_bus import mbs_pkg::*; #(
	parameter logic [2:0]  PAGE_GROUP   = 3'h0,
	parameter logic        CHIP_HALF    = 1'b0,
	parameter logic        IOB_MODE     = 1'b0,
	parameter mbs_module_t PORT_A_NUM   = 6'h3D,
	parameter mbs_module_t PORT_B_NUM   = 6'h3E,
	parameter logic        PROC_PORT_EN = 1'b1,
	parameter int          SLOT_CLKS    = `MBS_SLOT_CLKS,
	parameter int          MEM_WORDS    = `MBS_MEM_WORDS
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        transfer_direction_line,
	input  wire logic        data_or_address_line,
	input  wire logic        pointer_select_line,
	input  wire logic        stack_operation_line,
	input  wire mbs_module_t module_select_bus,
	input  wire mbs_word_t   data_bus_in,
	output mbs_word_t        data_bus_out,
	output mbs_word_t        data_bus_oe,
	input  wire logic [2:0]  pair_select,
	input  wire logic [15:0] port_pin_in,
	output logic [15:0]      port_pin_out,
	output logic [15:0]      port_pin_oe,
	input  wire mbs_word_t   proc_pin_in,
	output logic [3:0]       proc_pin_out,
	output logic [3:0]       proc_pin_oe,
	output logic [2:0]       machine_slot,
	output logic             module_active
);
	localparam int MAW = $clog2(MEM_WORDS);

	logic [11:0]            slot_cnt;
	logic                   slot_end;
	logic                   cycle_end;
	logic [3:0]             code_q;
	mbs_module_t            msb_q;
	mbs_op_t                op;
	mbs_word_t              wr_data;
	logic                   group_hit;
	logic                   chip_hit;
	logic [1:0]             port_hit;
	logic                   proc_hit;
	logic                   rd_op;
	mbs_word_t              rd_val;
	mbs_word_t              port_rd [2];
	mbs_word_t              proc_rd;
	logic [`MBS_ADDR_W-1:0] q;
	logic [`MBS_ADDR_W-1:0] q_top;
	logic [`MBS_ADDR_W-1:0] z;
	logic [`MBS_ADDR_W-1:0] next_ptr;
	mbs_word_t              mem [MEM_WORDS];

	////////////////////////////////////////////////////////////////////////
	// machine cycle: eight slots T1..T8

	assign slot_end  = (slot_cnt == 12'(SLOT_CLKS - 1));
	assign cycle_end = slot_end && (machine_slot == `MBS_SLOT_LAST);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			slot_cnt <= '0;
		end else if (slot_end) begin
			slot_cnt <= '0;
		end else begin
			slot_cnt <= slot_cnt + 12'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			machine_slot <= 3'h0;
		end else if (slot_end) begin
			machine_slot <= machine_slot + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control and module number capture in T5

	always_ff @(posedge clk) begin
		if (!nrst) begin
			code_q <= `MBS_CODE_NOP;
			msb_q  <= 6'h00;
		end else if (slot_end && machine_slot == `MBS_SLOT_ADDR) begin
			code_q <= {transfer_direction_line, data_or_address_line,
				pointer_select_line, stack_operation_line};
			msb_q  <= module_select_bus;
		end
	end

	// unlisted codes do nothing
	always_comb begin
		case (code_q)
			`MBS_CODE_FETCH:  op = MBS_OP_FETCH;
			`MBS_CODE_READ_Z: op = MBS_OP_READ_Z;
			`MBS_CODE_NOP:    op = MBS_OP_NOP;
			`MBS_CODE_RETURN: op = MBS_OP_RETURN;
			`MBS_CODE_WRITE:  op = MBS_OP_WRITE;
			`MBS_CODE_LOAD_Q: op = MBS_OP_LOAD_Q;
			`MBS_CODE_CALL:   op = MBS_OP_CALL;
			`MBS_CODE_LOAD_Z: op = MBS_OP_LOAD_Z;
			default:          op = MBS_OP_UNUSED;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// module selection

	assign group_hit = (msb_q[5:3] == PAGE_GROUP);
	// fetch follows pointer bit 11, other accesses module bit 3
	assign chip_hit  = group_hit && ((op == MBS_OP_FETCH) ?
		(q[10] == CHIP_HALF) : (msb_q[2] == CHIP_HALF));

	always_comb begin
		if (IOB_MODE) begin
			port_hit[0] = (msb_q[5:4] == `MBS_IOB_RANGE) && (msb_q[3:1] == pair_select)
				&& !msb_q[0];
			port_hit[1] = (msb_q[5:4] == `MBS_IOB_RANGE) && (msb_q[3:1] == pair_select)
				&& msb_q[0];
		end else begin
			port_hit[0] = (msb_q == PORT_A_NUM);
			port_hit[1] = (msb_q == PORT_B_NUM);
		end
	end

	assign proc_hit      = PROC_PORT_EN && (msb_q == `MBS_PROC_PORT);
	assign module_active = chip_hit || (|port_hit) || proc_hit;

	////////////////////////////////////////////////////////////////////////
	// bus drive: discharge in T7-T8, inverted, only where data is one

	assign rd_op   = (op == MBS_OP_FETCH) || (op == MBS_OP_READ_Z);
	assign wr_data = ~data_bus_in;

	always_comb begin
		if (chip_hit) begin
			rd_val = mem[(op == MBS_OP_FETCH) ? q[MAW-1:0] : z[MAW-1:0]];
		end else if (port_hit[0]) begin
			rd_val = port_rd[0];
		end else if (port_hit[1]) begin
			rd_val = port_rd[1];
		end else if (proc_hit) begin
			rd_val = proc_rd;
		end else begin
			rd_val = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			data_bus_out <= `MBS_BUS_IDLE;
			data_bus_oe  <= 8'h00;
		end else if (slot_end && machine_slot == `MBS_SLOT_PREP) begin
			data_bus_out <= ~rd_val;
			data_bus_oe  <= (rd_op && module_active) ? rd_val : 8'h00;
		end else if (cycle_end) begin
			data_bus_out <= `MBS_BUS_IDLE;
			data_bus_oe  <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pointers, stack and memory array; writes at the end of T8

	assign next_ptr = {msb_q[2:0], wr_data};

	mbs_pointer_stack #(
		.AW    (`MBS_ADDR_W),
		.DEPTH (`MBS_STACK_DEPTH)
	) u_pc (
		.clk      (clk),
		.nrst     (nrst),
		.load     (cycle_end && group_hit && (op == MBS_OP_LOAD_Q || op == MBS_OP_CALL)),
		.push     (cycle_end && group_hit && op == MBS_OP_CALL),
		.pop      (cycle_end && group_hit && op == MBS_OP_RETURN),
		.inc      (cycle_end && group_hit && op == MBS_OP_FETCH),
		.load_val (next_ptr),
		.ptr      (q),
		.top      (q_top)
	);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			z <= '0;
		end else if (cycle_end && group_hit && op == MBS_OP_LOAD_Z) begin
			z <= next_ptr;
		end
	end

	always_ff @(posedge clk) begin
		if (cycle_end && chip_hit && op == MBS_OP_WRITE) begin
			mem[z[MAW-1:0]] <= wr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// io ports

	for (genvar i = 0; i < 2; i++) begin : g_port
		mbs_io_port #(
			.LATCH_W (8)
		) u_port (
			.clk     (clk),
			.nrst    (nrst),
			.wr_stb  (cycle_end && port_hit[i] && op == MBS_OP_WRITE),
			.wr_data (wr_data),
			.rd_data (port_rd[i]),
			.pin_in  (port_pin_in[8*i +: 8]),
			.pin_out (port_pin_out[8*i +: 8]),
			.pin_oe  (port_pin_oe[8*i +: 8])
		);
	end

	mbs_io_port #(
		.LATCH_W (4)
	) u_proc_port (
		.clk     (clk),
		.nrst    (nrst),
		.wr_stb  (cycle_end && proc_hit && op == MBS_OP_WRITE),
		.wr_data (wr_data),
		.rd_data (proc_rd),
		.pin_in  (proc_pin_in),
		.pin_out (proc_pin_out),
		.pin_oe  (proc_pin_oe)
	);

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	AST_DRIVE_SLOTS: assert property (
		|data_bus_oe |-> (machine_slot == `MBS_SLOT_DRV || machine_slot == `MBS_SLOT_LAST))
		else $error("bus driven outside T7-T8");
	AST_DRIVE_SELECTED: assert property (
		|data_bus_oe |-> module_active && rd_op)
		else $error("bus driven while not selected for a read");
	AST_DRIVE_INVERTED: assert property (
		|data_bus_oe |-> (data_bus_out & data_bus_oe) == 8'h00)
		else $error("driven bit not low");
	AST_LOAD_Q: assert property (
		cycle_end && group_hit && op == MBS_OP_LOAD_Q
		|=> q == {$past(msb_q[2:0]), ~$past(data_bus_in)})
		else $error("program pointer load wrong");
	AST_LOAD_Z: assert property (
		cycle_end && group_hit && op == MBS_OP_LOAD_Z
		|=> z == {$past(msb_q[2:0]), ~$past(data_bus_in)})
		else $error("data pointer load wrong");
	AST_FETCH_INC: assert property (
		cycle_end && group_hit && op == MBS_OP_FETCH |=> q == $past(q) + 11'h001)
		else $error("fetch did not advance pointer");
	AST_RETURN_POP: assert property (
		cycle_end && group_hit && op == MBS_OP_RETURN |=> q == $past(q_top))
		else $error("return did not restore pointer");
	AST_CALL_PUSH: assert property (
		cycle_end && group_hit && op == MBS_OP_CALL |=> q_top == $past(q))
		else $error("call did not save pointer");
	AST_PROC_LATCH: assert property (
		cycle_end && proc_hit && op == MBS_OP_WRITE
		|=> proc_pin_oe == ~$past(data_bus_in[7:4]))
		else $error("processor port latch wrong");
	AST_PORT_READ: assert property (
		port_hit[0] && !chip_hit && rd_op && slot_end && machine_slot == `MBS_SLOT_PREP
		|=> data_bus_oe == ($past(port_pin_in[7:0]) | $past(port_pin_oe[7:0])))
		else $error("port read not wire-ored");
	AST_RESET_LATCH: assert property (
		$rose(nrst) |-> port_pin_oe == 16'h0000 && proc_pin_oe == 4'h0)
		else $error("port latches not cleared");

	COV_FETCH: cover property (cycle_end && chip_hit && op == MBS_OP_FETCH);
	COV_CALL_RET: cover property (
		cycle_end && op == MBS_OP_CALL ##[1:300] cycle_end && op == MBS_OP_RETURN);
	COV_PORT_WRITE: cover property (cycle_end && |port_hit && op == MBS_OP_WRITE);
endmodule
`default_nettype wire

//--- common/mbs_defines.svh
`ifndef MBS_DEFINES_SVH
`define MBS_DEFINES_SVH
`define MBS_CLK_NS      10
`define MBS_SLOT_NS     625
`define MBS_SLOT_CLKS   (`MBS_SLOT_NS / `MBS_CLK_NS)
`define MBS_SLOT_ADDR   3'h4
`define MBS_SLOT_PREP   3'h5
`define MBS_SLOT_DRV    3'h6
`define MBS_SLOT_LAST   3'h7
`define MBS_CODE_FETCH  4'h0
`define MBS_CODE_READ_Z 4'h2
`define MBS_CODE_NOP    4'h4
`define MBS_CODE_RETURN 4'h5
`define MBS_CODE_WRITE  4'h8
`define MBS_CODE_LOAD_Q 4'hC
`define MBS_CODE_CALL   4'hD
`define MBS_CODE_LOAD_Z 4'hE
`define MBS_PROC_PORT   6'h3F
`define MBS_IOB_RANGE   2'h3
`define MBS_PORT_RESET  8'h00
`define MBS_BUS_IDLE    8'hFF
`define MBS_STACK_DEPTH 4
`define MBS_ADDR_W      11
`define MBS_MEM_WORDS   1024
`endif

//--- common/mbs_pkg.sv
package mbs_pkg;
	typedef enum logic [3:0] {
		MBS_OP_FETCH,
		MBS_OP_READ_Z,
		MBS_OP_NOP,
		MBS_OP_RETURN,
		MBS_OP_WRITE,
		MBS_OP_LOAD_Q,
		MBS_OP_CALL,
		MBS_OP_LOAD_Z,
		MBS_OP_UNUSED
	} mbs_op_t;
	typedef logic [5:0] mbs_module_t;
	typedef logic [7:0] mbs_word_t;
endpackage

//--- rtl/mbs_io_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "mbs_defines.svh"
module mbs_io_port import mbs_pkg::*; #(
	parameter int LATCH_W = 8
) (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic               wr_stb,
	input  wire mbs_word_t          wr_data,
	output mbs_word_t               rd_data,
	input  wire mbs_word_t          pin_in,
	output logic [LATCH_W-1:0]      pin_out,
	output logic [LATCH_W-1:0]      pin_oe
);
	logic [LATCH_W-1:0] latch;

	// latches sit on the upper bits, clear at reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			latch <= LATCH_W'(`MBS_PORT_RESET);
		end else if (wr_stb) begin
			latch <= wr_data[7 -: LATCH_W];
		end
	end

	// open drain: transistor on where latch is set, pins wire-ored with latches
	assign pin_out = latch;
	assign pin_oe  = latch;
	assign rd_data = pin_in | {latch, {(8 - LATCH_W){1'b0}}};
endmodule
`default_nettype wire

//--- rtl/mbs_pointer_stack.sv
`timescale 1ns/1ns
`default_nettype none
`include "mbs_defines.svh"
module mbs_pointer_stack #(
	parameter int AW    = `MBS_ADDR_W,
	parameter int DEPTH = `MBS_STACK_DEPTH
) (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          load,
	input  wire logic          push,
	input  wire logic          pop,
	input  wire logic          inc,
	input  wire logic [AW-1:0] load_val,
	output logic      [AW-1:0] ptr,
	output logic      [AW-1:0] top
);
	logic [DEPTH*AW-1:0] stk;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ptr <= '0;
		end else if (load) begin
			ptr <= load_val;
		end else if (pop) begin
			ptr <= top;
		end else if (inc) begin
			ptr <= ptr + AW'(1);
		end
	end

	// shift stack, bottom entry repeats on pop
	always_ff @(posedge clk) begin
		if (!nrst) begin
			stk <= '0;
		end else if (push) begin
			stk <= {stk[(DEPTH-1)*AW-1:0], ptr};
		end else if (pop) begin
			stk <= {stk[DEPTH*AW-1 -: AW], stk[DEPTH*AW-1:AW]};
		end
	end

	assign top = stk[AW-1:0];
endmodule
`default_nettype wire

//--- verification/mbs_proc_model.sv
`timescale 1ns/1ns
`default_nettype none
module mbs_proc_model import mbs_pkg::*; #(
	parameter int S = 4
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire mbs_word_t   data_bus_oe,
	output logic [3:0]       ctrl,
	output mbs_module_t      mod,
	output mbs_word_t        data_bus_in
);
	int        p;
	mbs_word_t lvl;
	////////////////////////////////////////////////////////////////
	// precharged wire, pulled low by any module
	assign data_bus_in = lvl & ~data_bus_oe;
	always_ff @(posedge clk) begin
		if (!nrst)
			p <= 0;
		else
			p <= (p == 8*S-1) ? 0 : p + 1;
	end
	initial begin
		ctrl = 4'h4;
		mod  = 6'h00;
		lvl  = 8'hFF;
	end
	////////////////////////////////////////////////////////////////
	// one machine cycle
	task automatic run(input logic [3:0] c, input mbs_module_t m, input mbs_word_t d,
		output mbs_word_t rd);
		@(posedge clk iff p == 8*S-1);
		ctrl <= c;
		mod  <= m;
		lvl  <= c[3] ? ~d : 8'hFF;
		@(posedge clk iff p == 7*S+1);
		rd = ~data_bus_in;
	endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb import mbs_pkg::*;;
	localparam int          S  = 4;
	localparam mbs_module_t PA = 6'h3A;
	localparam mbs_module_t PB = 6'h3B;
	localparam mbs_module_t PC = 6'h3D;
	localparam mbs_module_t PP = 6'h3F;
	localparam mbs_module_t MM = 6'h02;
	logic        clk;
	logic        nrst;
	logic [3:0]  ctrl;
	mbs_module_t mod;
	mbs_word_t   dbi, dbo, dboe, dboe2, pp_in, rd, lat_a, lat_b, lat_p, lat_c, a;
	mbs_word_t   v [4];
	logic [15:0] pin_in, pin_out, pin_oe, pin_out2;
	logic [3:0]  ppo, ppoe;
	logic [2:0]  psel, slot;
	logic        act;
	logic [31:0] r;
	int          failures = 0;
	int          n_checks = 0;
	int          seed = 77;
	logic [3:0]  bad [8] = '{4'h1, 4'h3, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hF};
	mbs_module_t miss [3] = '{6'h1A, 6'h3C, 6'h38};
	////////////////////////////////////////////////////////////////
	mbs_module_bus #(.IOB_MODE(1'b1), .SLOT_CLKS(S)) i_dut (.clk(clk), .nrst(nrst),
		.transfer_direction_line(ctrl[3]), .data_or_address_line(ctrl[2]),
		.pointer_select_line(ctrl[1]), .stack_operation_line(ctrl[0]),
		.module_select_bus(mod), .data_bus_in(dbi), .data_bus_out(dbo), .data_bus_oe(dboe),
		.pair_select(psel), .port_pin_in(pin_in), .port_pin_out(pin_out),
		.port_pin_oe(pin_oe), .proc_pin_in(pp_in), .proc_pin_out(ppo), .proc_pin_oe(ppoe),
		.machine_slot(slot), .module_active(act));
	// second module on the same bus: numbered ports, no processor port
	mbs_module_bus #(.PAGE_GROUP(3'h1), .CHIP_HALF(1'b1), .PORT_A_NUM(PC),
		.PROC_PORT_EN(1'b0), .SLOT_CLKS(S)) i_dut_b (.clk(clk), .nrst(nrst),
		.transfer_direction_line(ctrl[3]), .data_or_address_line(ctrl[2]),
		.pointer_select_line(ctrl[1]), .stack_operation_line(ctrl[0]),
		.module_select_bus(mod), .data_bus_in(dbi), .data_bus_out(), .data_bus_oe(dboe2),
		.pair_select(psel), .port_pin_in(pin_in), .port_pin_out(pin_out2),
		.port_pin_oe(), .proc_pin_in(pp_in), .proc_pin_out(), .proc_pin_oe(),
		.machine_slot(), .module_active());
	mbs_proc_model #(.S(S)) i_proc (.clk(clk), .nrst(nrst), .data_bus_oe(dboe | dboe2),
		.ctrl(ctrl), .mod(mod), .data_bus_in(dbi));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	function automatic mbs_word_t port_rd(input mbs_word_t pins, input mbs_word_t lat);
		return pins | lat;
	endfunction
	function automatic mbs_word_t proc_lat(input mbs_word_t d);
		return {d[7:4], 4'h0};
	endfunction
	task automatic chk_w(input mbs_word_t got, input mbs_word_t exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_p(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic op(input logic [3:0] c, input mbs_module_t m, input mbs_word_t d);
		i_proc.run(c, m, d, rd);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		give_verdict;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		psel = 3'h5;
		pin_in = 16'h0000;
		pp_in = 8'h00;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		op(4'h0, PA, 8'h00);
		chk_w(rd, 8'h00);
		op(4'h0, PB, 8'h00);
		chk_w(rd, 8'h00);
		op(4'h0, PP, 8'h00);
		chk_w(rd, 8'h00);
		chk_p(pin_oe, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			lat_a = (i == 5) ? 8'h00 : r[7:0];
			lat_b = r[15:8];
			@(posedge clk);
			pin_in <= r[31:16];
			op(4'h8, PA, lat_a);
			op(4'h8, PB, lat_b);
			op(4'h0, PA, 8'h00);
			chk_w(rd, port_rd(pin_in[7:0], lat_a));
			chk_w(dbo, ~port_rd(pin_in[7:0], lat_a));
			chk_w({7'h00, act}, 8'h01);
			chk_w({5'h00, slot}, 8'h07);
			op(4'h0, PB, 8'h00);
			chk_w(rd, port_rd(pin_in[15:8], lat_b));
			chk_p(pin_out, {lat_b, lat_a});
			chk_p(pin_oe, {lat_b, lat_a});
		end
		r = $random(seed);
		lat_p = r[7:0];
		@(posedge clk);
		pp_in <= r[15:8];
		op(4'h8, PP, lat_p);
		op(4'h0, PP, 8'h00);
		chk_w(rd, port_rd(pp_in, proc_lat(lat_p)));
		chk_w({ppo, 4'h0}, proc_lat(lat_p));
		chk_w({ppoe, 4'h0}, proc_lat(lat_p));
		r = $random(seed);
		lat_c = r[7:0];
		op(4'h8, PC, lat_c);
		op(4'h0, PC, 8'h00);
		chk_w(rd, port_rd(pin_in[7:0], lat_c));
		chk_w(dbo, 8'hFF);
		chk_p(pin_out2, {8'h00, lat_c});
		foreach (miss[i]) begin
			op(4'h8, miss[i], 8'h5A);
			op(4'h0, miss[i], 8'h00);
			chk_w(rd, 8'h00);
			chk_w({7'h00, act}, 8'h00);
		end
		foreach (bad[i])
			op(bad[i], PA, 8'hFF);
		op(4'h0, PA, 8'h00);
		chk_w(rd, port_rd(pin_in[7:0], lat_a));
		r = $random(seed);
		{v[3], v[2], v[1], v[0]} = r;
		r = $random(seed);
		a = {1'b0, r[6:0]};
		for (int i = 0; i < 3; i++) begin
			op(4'hE, MM, a + 8'(i));
			op(4'h8, MM, v[i]);
		end
		op(4'hE, MM, a + 8'h80);
		op(4'h8, MM, v[3]);
		op(4'hE, MM, a);
		op(4'h2, MM, 8'h00);
		chk_w(rd, v[0]);
		op(4'h2, 6'h06, 8'h00);
		chk_w(rd, 8'h00);
		op(4'hC, MM, a);
		op(4'h0, MM, 8'h00);
		chk_w(rd, v[0]);
		op(4'h0, MM, 8'h00);
		chk_w(rd, v[1]);
		op(4'hD, MM, a + 8'h80);
		op(4'hC, 6'h0A, a);
		op(4'h0, MM, 8'h00);
		chk_w(rd, v[3]);
		op(4'h5, MM, 8'h00);
		op(4'h0, MM, 8'h00);
		chk_w(rd, v[2]);
		give_verdict;
	end
endmodule
`default_nettype wire
